/* File: logic/fpes_regs.svh */
// Opcodes, address masks, protection sizes and timing counts
`ifndef FPES_REGS_SVH
`define FPES_REGS_SVH

`define FPES_OP_PROG      8'h02
`define FPES_OP_QPROG     8'h32
`define FPES_OP_SECT      8'h20
`define FPES_OP_HALF      8'h52
`define FPES_OP_FULL      8'hD8

`define FPES_PAGE_MASK    24'h0000FF
`define FPES_SECT_MASK    24'h000FFF
`define FPES_HALF_MASK    24'h007FFF
`define FPES_FULL_MASK    24'h00FFFF
`define FPES_ARRAY_SIZE   24'h020000
`define FPES_PROT_FINE    24'h001000
`define FPES_PROT_COARSE  24'h008000
`define FPES_LAST_ADDR    2'h2
`define FPES_LAST_SLOT    8'hFF

`define FPES_CLK_MHZ      100
`define FPES_PP_US        1000
`define FPES_SE_US        50000
`define FPES_HB_US        150000
`define FPES_BE_US        250000
`define FPES_PP_CYC       (`FPES_PP_US * `FPES_CLK_MHZ)
`define FPES_SE_CYC       (`FPES_SE_US * `FPES_CLK_MHZ)
`define FPES_HB_CYC       (`FPES_HB_US * `FPES_CLK_MHZ)
`define FPES_BE_CYC       (`FPES_BE_US * `FPES_CLK_MHZ)

`define FPES_FIFO_WIDTH   32
`define FPES_FIFO_DEPTH   16

`endif

/* File: logic/fpes_pkg.sv */
// Types shared by the program and erase sequencer
package fpes_pkg;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_OPC  = 2'b01,
    FR_ADDR = 2'b11,
    FR_DATA = 2'b10
  } fpes_frame_type;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_SCAN = 2'b01,
    EX_WAIT = 2'b11
  } fpes_exec_type;

  typedef enum logic [1:0] {
    ER_SECT = 2'b00,
    ER_HALF = 2'b01,
    ER_FULL = 2'b10
  } fpes_erase_type;

endpackage : fpes_pkg

/* File: logic/fpes_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module fpes_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = ce_i ? async_i : meta_reg;
    sync_next = ce_i ? meta_reg : sync_reg;
  end

  // Reset to all ones so an idle select pin reads deasserted
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule : fpes_sync

/* File: logic/fpes_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module fpes_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  empty_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             full;
  logic             push;
  logic             pop;

  assign full        = (wr_reg[AW] != rd_reg[AW]) &&
                       (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty_o     = (wr_reg == rd_reg);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty_o;
  assign out_data_o  = mem_reg[rd_reg[AW-1:0]];
  assign push        = ce_i && in_valid_i && !full;
  assign pop         = ce_i && out_ready_i && !empty_o;

  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg + (AW+1)'(push);
    rd_next  = rd_reg + (AW+1)'(pop);
    if (push) begin
      mem_next[wr_reg[AW-1:0]] = in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      mem_reg <= mem_next;
    end
  end
endmodule : fpes_fifo

/* File: logic/fpes_sequencer.sv */
// Functional notes
// - Program: opcode 02h, 24-bit address, data bytes
// - Program accepted only with write latch set
// - Low address byte is page offset, wraps
// - Over 256 bytes: later bytes replace earlier
// - Partial program leaves other page bytes
// - Select must rise on a byte boundary
// - Select rise starts timed cycle, busy held
// - Completed program clears write latch
// - Protected page is never programmed
// - Quad program 32h needs quad enable set
// - Sector erase 20h clears 4K sector
// - Erase only if select rises after address
// - Sector erase busy, then clears latch
// - Protected sector erase is refused
// - Opcode 52h erases a 32K block
// - Opcode D8h erases a 64K block
// - Block erase busy, then clears latch
// - Protected block erase is refused
`timescale 1ns/1ps
`include "fpes_regs.svh"
module fpes_sequencer #(
  parameter logic [31:0] PROGRAM_CYCLES    = `FPES_PP_CYC,
  parameter logic [31:0] SECTOR_CYCLES     = `FPES_SE_CYC,
  parameter logic [31:0] HALF_BLOCK_CYCLES = `FPES_HB_CYC,
  parameter logic [31:0] BLOCK_CYCLES      = `FPES_BE_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Link pins
  input  wire logic        link_clk_i,
  input  wire logic        link_sel_n_i,
  input  wire logic        serial_in_i,
  input  wire logic [2:0]  quad_io_upper_i,
  // Control and status
  input  wire logic        write_latch_set_i,
  input  wire logic        quad_lanes_enable_i,
  input  wire logic        protect_invert_i,
  input  wire logic        protect_granularity_i,
  input  wire logic        protect_top_bottom_i,
  input  wire logic [2:0]  protect_range_i,
  output logic             write_latch_flag_o,
  output logic             op_in_progress_o,
  // Array program port
  output logic             arr_prog_valid_o,
  input  wire logic        arr_prog_ready_i,
  output logic [23:0]      arr_prog_addr_o,
  output logic [7:0]       arr_prog_data_o,
  // Array erase port
  output logic             arr_erase_o,
  output logic [23:0]      arr_erase_addr_o,
  output logic [1:0]       arr_erase_kind_o
);
  // Pin sampling and edges
  logic [5:0] pins_s;
  logic       sclk_q_reg;
  logic       sel_q_reg;
  logic       sclk_rise;
  logic       sel_rise;
  logic       sel_fall;
  logic [3:0] lanes;

  fpes_sync #(.WIDTH(6)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i ({link_clk_i, link_sel_n_i, quad_io_upper_i, serial_in_i}),
    .sync_o  (pins_s)
  );

  assign lanes     = pins_s[3:0];
  assign sclk_rise = pins_s[5] && !sclk_q_reg;
  assign sel_rise  = pins_s[4] && !sel_q_reg;
  assign sel_fall  = !pins_s[4] && sel_q_reg;

  // Frame state
  fpes_pkg::fpes_frame_type fr_reg, fr_next;
  logic [2:0]  cnt_reg, cnt_next, cnt_inc;
  logic [7:0]  sh_reg, sh_next, sh_shift;
  logic [7:0]  op_reg, op_next;
  logic [23:0] addr_reg, addr_next;
  logic [1:0]  ab_reg, ab_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic        data_reg, data_next;
  logic        quad_reg, quad_next;
  logic        drop_reg, drop_next;
  logic [7:0]  pbuf_reg [256];
  logic [7:0]  pbuf_next [256];
  logic [255:0] pmask_reg, pmask_next;
  logic        quad_now;
  logic        byte_done;
  logic        byte_wr;
  // Launch decision
  logic        is_prog, is_erase, aligned, prot_hit, launch;
  logic [23:0] span;
  logic [23:0] base;
  // Execution state
  fpes_pkg::fpes_exec_type ex_reg, ex_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [7:0]  scan_reg, scan_next;
  logic [15:0] page_reg, page_next;
  logic        wlf_reg, wlf_next;
  logic        er_reg, er_next;
  logic [23:0] er_addr_reg, er_addr_next;
  logic [1:0]  er_kind_reg, er_kind_next;
  logic        ex_done;
  logic        push;
  logic        fifo_ready;
  logic        fifo_empty;
  logic [31:0] fifo_out;

  // Overlap of [lo,hi] with the protected region
  function automatic logic prot_f(input logic [23:0] lo,
                                  input logic [23:0] hi);
    logic [23:0] unit;
    logic [23:0] size;
    logic [23:0] r_lo;
    logic [23:0] r_hi;
    logic        hit;
    unit = protect_granularity_i ? `FPES_PROT_FINE : `FPES_PROT_COARSE;
    size = (protect_range_i == 3'h0) ? 24'h0 :
           unit << (protect_range_i - 3'h1);
    if (size > `FPES_ARRAY_SIZE) begin
      size = `FPES_ARRAY_SIZE;
    end
    r_lo = protect_top_bottom_i ? 24'h0 : `FPES_ARRAY_SIZE - size;
    r_hi = protect_top_bottom_i ? size : `FPES_ARRAY_SIZE;
    hit  = (size != 24'h0) && (lo < r_hi) && (hi >= r_lo);
    if (protect_invert_i) begin
      hit = (lo < r_lo) || (hi >= r_hi);
    end
    return hit;
  endfunction : prot_f

  assign is_prog  = (op_reg == `FPES_OP_PROG) ||
                    (op_reg == `FPES_OP_QPROG);
  assign is_erase = (op_reg == `FPES_OP_SECT) ||
                    (op_reg == `FPES_OP_HALF) ||
                    (op_reg == `FPES_OP_FULL);
  assign aligned  = (cnt_reg == 3'h0);

  always_comb begin
    case (op_reg)
      `FPES_OP_SECT: span = `FPES_SECT_MASK;
      `FPES_OP_HALF: span = `FPES_HALF_MASK;
      `FPES_OP_FULL: span = `FPES_FULL_MASK;
      default:       span = `FPES_PAGE_MASK;
    endcase
  end

  assign base     = addr_reg & ~span;
  // Process form, so protect pin changes re-run the check
  always_comb begin
    prot_hit = prot_f(base, base | span);
  end
  // Refused commands leave array and busy untouched
  assign launch   = sel_rise && aligned && !drop_reg && wlf_reg &&
                    !prot_hit && (ex_reg == fpes_pkg::EX_IDLE) &&
                    (fr_reg == fpes_pkg::FR_DATA) &&
                    ((is_prog && data_reg) ||
                     (is_erase && !data_reg));

  // Opcode always arrives on the single line
  assign quad_now  = quad_reg && (fr_reg != fpes_pkg::FR_OPC);
  assign cnt_inc   = quad_now ? 3'h4 : 3'h1;
  assign cnt_next  = sclk_rise ? cnt_reg + cnt_inc : cnt_reg;
  assign sh_shift  = quad_now ? {sh_reg[3:0], lanes} :
                                {sh_reg[6:0], lanes[0]};
  assign byte_done = !pins_s[4] && sclk_rise && (fr_reg != fpes_pkg::FR_IDLE)
                     && (cnt_reg + cnt_inc == 3'h0);
  assign byte_wr   = byte_done && (fr_reg == fpes_pkg::FR_DATA) &&
                     is_prog && !drop_reg;

  always_comb begin
    fr_next    = fr_reg;
    sh_next    = sclk_rise ? sh_shift : sh_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    ab_next    = ab_reg;
    ptr_next   = ptr_reg;
    data_next  = data_reg;
    quad_next  = quad_reg;
    drop_next  = drop_reg;
    pbuf_next  = pbuf_reg;
    pmask_next = pmask_reg;
    if (sel_rise || pins_s[4]) begin
      fr_next = fpes_pkg::FR_IDLE;
    end else if (sel_fall) begin
      fr_next   = fpes_pkg::FR_OPC;
      data_next = 1'b0;
      quad_next = 1'b0;
      drop_next = 1'b0;
      ab_next   = 2'h0;
    end else if (byte_done) begin
      case (fr_reg)
        fpes_pkg::FR_OPC: begin
          op_next   = sh_shift;
          quad_next = (sh_shift == `FPES_OP_QPROG);
          drop_next = (ex_reg != fpes_pkg::EX_IDLE) ||
                      !((sh_shift == `FPES_OP_PROG) ||
                        (sh_shift == `FPES_OP_QPROG) ||
                        (sh_shift == `FPES_OP_SECT) ||
                        (sh_shift == `FPES_OP_HALF) ||
                        (sh_shift == `FPES_OP_FULL)) ||
                      ((sh_shift == `FPES_OP_QPROG) &&
                       !quad_lanes_enable_i);
          // Fresh page image only when it can be used
          if (ex_reg == fpes_pkg::EX_IDLE) begin
            pmask_next = '0;
          end
          fr_next = fpes_pkg::FR_ADDR;
        end
        fpes_pkg::FR_ADDR: begin
          addr_next = {addr_reg[15:0], sh_shift};
          ab_next   = ab_reg + 2'h1;
          if (ab_reg == `FPES_LAST_ADDR) begin
            ptr_next = sh_shift;
            fr_next  = fpes_pkg::FR_DATA;
          end
        end
        fpes_pkg::FR_DATA: begin
          data_next = 1'b1;
          if (byte_wr) begin
            pbuf_next[ptr_reg]  = sh_shift;
            pmask_next[ptr_reg] = 1'b1;
            ptr_next            = ptr_reg + 8'h01;
          end
        end
        default: fr_next = fpes_pkg::FR_IDLE;
      endcase
    end
  end

  // Program and erase execution
  assign push    = (ex_reg == fpes_pkg::EX_SCAN) && pmask_reg[scan_reg];
  assign ex_done = (ex_reg == fpes_pkg::EX_WAIT) && (tmr_reg == 32'h0) &&
                   fifo_empty;

  always_comb begin
    ex_next      = ex_reg;
    tmr_next     = (tmr_reg != 32'h0) ? tmr_reg - 32'h1 : tmr_reg;
    scan_next    = scan_reg;
    page_next    = page_reg;
    er_next      = 1'b0;
    er_addr_next = er_addr_reg;
    er_kind_next = er_kind_reg;
    wlf_next     = wlf_reg;
    case (ex_reg)
      fpes_pkg::EX_IDLE: begin
        if (launch && is_prog) begin
          ex_next   = fpes_pkg::EX_SCAN;
          tmr_next  = PROGRAM_CYCLES - 32'h1;
          scan_next = 8'h00;
          page_next = addr_reg[23:8];
        end else if (launch) begin
          ex_next      = fpes_pkg::EX_WAIT;
          er_next      = 1'b1;
          er_addr_next = base;
          case (op_reg)
            `FPES_OP_HALF: begin
              er_kind_next = fpes_pkg::ER_HALF;
              tmr_next     = HALF_BLOCK_CYCLES - 32'h1;
            end
            `FPES_OP_FULL: begin
              er_kind_next = fpes_pkg::ER_FULL;
              tmr_next     = BLOCK_CYCLES - 32'h1;
            end
            default: begin
              er_kind_next = fpes_pkg::ER_SECT;
              tmr_next     = SECTOR_CYCLES - 32'h1;
            end
          endcase
        end
      end
      fpes_pkg::EX_SCAN: begin
        // Only bytes sent in this command reach the array
        if (!push || fifo_ready) begin
          scan_next = scan_reg + 8'h01;
          if (scan_reg == `FPES_LAST_SLOT) begin
            ex_next = fpes_pkg::EX_WAIT;
          end
        end
      end
      fpes_pkg::EX_WAIT: begin
        if (ex_done) begin
          ex_next  = fpes_pkg::EX_IDLE;
          wlf_next = 1'b0;
        end
      end
      default: ex_next = fpes_pkg::EX_IDLE;
    endcase
    // A write enable in the completion cycle is kept
    if (write_latch_set_i) begin
      wlf_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Matches the synchroniser reset, so no false edge
      sclk_q_reg  <= 1'b1;
      sel_q_reg   <= 1'b1;
      fr_reg      <= fpes_pkg::FR_IDLE;
      cnt_reg     <= 3'h0;
      sh_reg      <= 8'h00;
      op_reg      <= 8'h00;
      addr_reg    <= 24'h000000;
      ab_reg      <= 2'h0;
      ptr_reg     <= 8'h00;
      data_reg    <= 1'b0;
      quad_reg    <= 1'b0;
      drop_reg    <= 1'b1;
      pmask_reg   <= '0;
      for (int i = 0; i < 256; i++) begin
        pbuf_reg[i] <= 8'hFF;
      end
      ex_reg      <= fpes_pkg::EX_IDLE;
      tmr_reg     <= 32'h0;
      scan_reg    <= 8'h00;
      page_reg    <= 16'h0000;
      wlf_reg     <= 1'b0;
      er_reg      <= 1'b0;
      er_addr_reg <= 24'h000000;
      er_kind_reg <= fpes_pkg::ER_SECT;
    end else if (ce_i) begin
      sclk_q_reg  <= pins_s[5];
      sel_q_reg   <= pins_s[4];
      fr_reg      <= fr_next;
      cnt_reg     <= (pins_s[4] || sel_fall) ? 3'h0 : cnt_next;
      sh_reg      <= sh_next;
      op_reg      <= op_next;
      addr_reg    <= addr_next;
      ab_reg      <= ab_next;
      ptr_reg     <= ptr_next;
      data_reg    <= data_next;
      quad_reg    <= quad_next;
      drop_reg    <= drop_next;
      pmask_reg   <= pmask_next;
      pbuf_reg    <= pbuf_next;
      ex_reg      <= ex_next;
      tmr_reg     <= tmr_next;
      scan_reg    <= scan_next;
      page_reg    <= page_next;
      wlf_reg     <= wlf_next;
      er_reg      <= er_next;
      er_addr_reg <= er_addr_next;
      er_kind_reg <= er_kind_next;
    end
  end

  // Array stalls back-pressure the page scan
  fpes_fifo #(
    .WIDTH (`FPES_FIFO_WIDTH),
    .DEPTH (`FPES_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({page_reg, scan_reg, pbuf_reg[scan_reg]}),
    .out_valid_o (arr_prog_valid_o),
    .out_ready_i (arr_prog_ready_i),
    .out_data_o  (fifo_out),
    .empty_o     (fifo_empty)
  );

  assign arr_prog_addr_o    = fifo_out[31:8];
  assign arr_prog_data_o    = fifo_out[7:0];
  assign arr_erase_o        = er_reg;
  assign arr_erase_addr_o   = er_addr_reg;
  assign arr_erase_kind_o   = er_kind_reg;
  assign write_latch_flag_o = wlf_reg;
  assign op_in_progress_o   = (ex_reg != fpes_pkg::EX_IDLE);

  // Checks
  default clocking cb @(posedge clk_i iff ce_i); endclocking
  default disable iff (rst_i);

  sequence s_launch_prog;
    launch && is_prog;
  endsequence
  sequence s_launch_erase;
    launch && is_erase;
  endsequence
  sequence s_wrap;
    byte_wr && (ptr_reg == 8'hFF);
  endsequence

  a_latch_needed: assert property ($rose(op_in_progress_o) |-> $past(wlf_reg))
    else $error("Busy set with write latch clear");
  a_byte_align: assert property ($rose(op_in_progress_o) |-> $past(aligned))
    else $error("Busy set off a byte boundary");
  a_prot_refuse: assert property ($rose(op_in_progress_o) |-> !$past(prot_hit))
    else $error("Busy set for a protected area");
  a_quad_gate: assert property (
    byte_done && (fr_reg == fpes_pkg::FR_OPC) && !quad_lanes_enable_i &&
    (sh_shift == `FPES_OP_QPROG) |=> drop_reg)
    else $error("Quad program kept without quad enable");
  a_busy_start: assert property (s_launch_prog |=> op_in_progress_o[*8])
    else $error("Busy not held after program start");
  a_busy_cause: assert property ($rose(op_in_progress_o) |-> $past(launch))
    else $error("Busy set without accepted command");
  a_latch_clear: assert property (ex_done && !write_latch_set_i |=>
                                  !wlf_reg && !op_in_progress_o)
    else $error("Latch or busy not cleared at end");
  a_page_wrap: assert property (s_wrap |=> ptr_reg == 8'h00)
    else $error("Page offset did not wrap");
  a_erase_issue: assert property (s_launch_erase |=>
                                  arr_erase_o ##1 !arr_erase_o)
    else $error("Erase not issued as one pulse");
endmodule : fpes_sequencer

/* File: dv/fpes_host_model.sv */
// Host controller model that drives the link pins of the sequencer
`timescale 1ns/1ps
module fpes_host_model (
  // Link pins
  output logic       link_clk_o,
  output logic       link_sel_n_o,
  output logic       serial_in_o,
  output logic [2:0] quad_io_upper_o
);
  localparam realtime HALF = 62.5;

  initial begin
    link_clk_o = 1'b0;
    link_sel_n_o = 1'b1;
    serial_in_o = 1'b0;
    quad_io_upper_o = 3'h0;
  end

  task automatic open_frame();
    link_sel_n_o = 1'b0;
    #HALF;
  endtask : open_frame

  // Top n bits of b, msb first, one or four lanes per clock
  task automatic send(input logic [7:0] b, input int n, input bit quad);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < n; i += (quad ? 4 : 1)) begin
      if (quad) begin
        {quad_io_upper_o, serial_in_o} = s[7:4];
      end else begin
        serial_in_o = s[7];
      end
      s = quad ? (s << 4) : (s << 1);
      #HALF;
      link_clk_o = 1'b1;
      #HALF;
      link_clk_o = 1'b0;
    end
  endtask : send

  // Lines get inverted so stale data is never mistaken for held data
  task automatic close_frame();
    #HALF;
    link_sel_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    quad_io_upper_o = ~quad_io_upper_o;
  endtask : close_frame
endmodule : fpes_host_model

/* File: dv/fpes_sequencer_bench.sv */
// Self-checking bench for the program and erase sequencer
`timescale 1ns/1ps
module fpes_sequencer_bench;
  localparam logic [31:0] CYC = 32'h0000012C;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        we_set = 1'b0;
  logic        ce = 1'b1;
  logic        quad_en = 1'b0;
  logic        p_inv = 1'b0;
  logic        p_gran = 1'b0;
  logic        p_tb = 1'b0;
  logic [2:0]  p_range = 3'h0;
  logic        p_ready = 1'b0;
  logic [1:0]  cyc = 2'h0;
  logic        lclk, sel_n, sin;
  logic [2:0]  qup;
  logic        latch, busy, p_valid, erase;
  logic [23:0] p_addr, e_addr;
  logic [7:0]  p_data;
  logic [1:0]  e_kind;
  logic [31:0] prog_q [$];
  logic [25:0] er_q [$];
  int          fail_count = 0;
  int          n_tests = 0;
  logic [7:0]  ops [3] = '{8'h20, 8'h52, 8'hD8};
  logic [25:0] ers [3] = '{{2'h0, 24'h01A000}, {2'h1, 24'h018000},
                           {2'h2, 24'h010000}};

  always #5 clk_i = ~clk_i;

  fpes_host_model i_fpes_host_model (.link_clk_o(lclk), .link_sel_n_o(sel_n),
    .serial_in_o(sin), .quad_io_upper_o(qup));

  fpes_sequencer #(.PROGRAM_CYCLES(CYC), .SECTOR_CYCLES(CYC),
    .HALF_BLOCK_CYCLES(CYC), .BLOCK_CYCLES(CYC)) i_fpes_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .link_clk_i(lclk),
    .link_sel_n_i(sel_n), .serial_in_i(sin), .quad_io_upper_i(qup),
    .write_latch_set_i(we_set), .quad_lanes_enable_i(quad_en),
    .protect_invert_i(p_inv), .protect_granularity_i(p_gran),
    .protect_top_bottom_i(p_tb), .protect_range_i(p_range),
    .write_latch_flag_o(latch), .op_in_progress_o(busy),
    .arr_prog_valid_o(p_valid), .arr_prog_ready_i(p_ready),
    .arr_prog_addr_o(p_addr), .arr_prog_data_o(p_data),
    .arr_erase_o(erase), .arr_erase_addr_o(e_addr),
    .arr_erase_kind_o(e_kind));

  // Array stalls one cycle in four
  always @(posedge clk_i) begin
    cyc <= cyc + 2'h1;
    p_ready <= (cyc != 2'h0);
    if (p_valid && p_ready) prog_q.push_back({p_addr, p_data});
    if (erase) er_q.push_back({e_kind, e_addr});
  end

  function automatic logic [7:0] dat(input int i);
    return i[7:0] ^ {7'h00, i[8]};
  endfunction : dat

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wren();
    @(posedge clk_i);
    we_set <= 1'b1;
    @(posedge clk_i);
    we_set <= 1'b0;
    @(negedge clk_i);
    check(latch, 1'b1);
  endtask : wren

  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input int n, input int extra, input bit q);
    i_fpes_host_model.open_frame();
    i_fpes_host_model.send(op, 8, 1'b0);
    for (int i = 2; i >= 0; i--) i_fpes_host_model.send(a[8*i +: 8], 8, q);
    for (int i = 0; i < n; i++) i_fpes_host_model.send(dat(i), 8, q);
    if (extra > 0) i_fpes_host_model.send(8'hA5, extra, 1'b0);
    i_fpes_host_model.close_frame();
  endtask : cmd

  task automatic outcome(input logic busy_exp, input logic latch_exp);
    int k;
    repeat (12) @(negedge clk_i);
    check(busy, busy_exp);
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    check(busy, 1'b0);
    check(latch, latch_exp);
    if (!busy_exp) check(prog_q.size() + er_q.size(), 0);
  endtask : outcome

  task automatic expect_prog(input logic [23:0] a, input int n);
    logic [7:0]  img [256];
    bit          hit [256];
    int          cnt;
    logic [31:0] e;
    cnt = 0;
    foreach (hit[s]) hit[s] = 1'b0;
    for (int k = 0; k < n; k++) begin
      img[8'(a[7:0] + k)] = dat(k);
      hit[8'(a[7:0] + k)] = 1'b1;
    end
    foreach (hit[s]) cnt += hit[s];
    check(prog_q.size(), cnt);
    while (prog_q.size() > 0) begin
      e = prog_q.pop_front();
      check(e[31:16], a[23:8]);
      check({hit[e[15:8]], e[7:0]}, {1'b1, img[e[15:8]]});
    end
  endtask : expect_prog

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #1_000_000;
    fail_count++;
    report_and_stop();
  end

  // Distinct pages each time, so the host only programs erased cells
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    // A frozen block must ignore a write enable pulse
    ce <= 1'b0;
    we_set <= 1'b1;
    @(posedge clk_i);
    we_set <= 1'b0;
    @(negedge clk_i);
    check(latch, 1'b0);
    @(posedge clk_i);
    ce <= 1'b1;
    wren();
    cmd(8'h02, 24'h0010FE, 3, 0, 0);
    outcome(1'b1, 1'b0);
    expect_prog(24'h0010FE, 3);
    cmd(8'h02, 24'h002000, 1, 0, 0);
    outcome(1'b0, 1'b0);
    $display("end of single program test");
    wren();
    cmd(8'h32, 24'h003010, 4, 0, 1);
    outcome(1'b0, 1'b1);
    @(posedge clk_i);
    quad_en <= 1'b1;
    cmd(8'h32, 24'h003010, 4, 0, 1);
    outcome(1'b1, 1'b0);
    expect_prog(24'h003010, 4);
    $display("end of quad program test");
    wren();
    cmd(8'h02, 24'h004000, 1, 3, 0);
    outcome(1'b0, 1'b1);
    cmd(8'h20, 24'h01A000, 0, 8, 0);
    outcome(1'b0, 1'b1);
    cmd(8'h20, 24'h01A000, 0, 4, 0);
    outcome(1'b0, 1'b1);
    $display("end of framing test");
    @(posedge clk_i);
    p_range <= 3'h1;
    p_tb <= 1'b1;
    cmd(8'h20, 24'h001000, 0, 0, 0);
    outcome(1'b0, 1'b1);
    cmd(8'h02, 24'h005000, 1, 0, 0);
    outcome(1'b0, 1'b1);
    cmd(8'h52, 24'h000000, 0, 0, 0);
    outcome(1'b0, 1'b1);
    // Fine granularity at the top end, then at the bottom end
    @(posedge clk_i);
    p_tb <= 1'b0;
    p_gran <= 1'b1;
    cmd(8'h20, 24'h01F000, 0, 0, 0);
    outcome(1'b0, 1'b1);
    @(posedge clk_i);
    p_tb <= 1'b1;
    cmd(8'h20, 24'h001000, 0, 0, 0);
    outcome(1'b1, 1'b0);
    check(er_q.size(), 1);
    if (er_q.size() != 0) check(er_q.pop_front(), {2'h0, 24'h001000});
    wren();
    @(posedge clk_i);
    p_gran <= 1'b0;
    p_inv <= 1'b1;
    cmd(8'h20, 24'h001000, 0, 0, 0);
    outcome(1'b1, 1'b0);
    check(er_q.size(), 1);
    if (er_q.size() != 0) check(er_q.pop_front(), {2'h0, 24'h001000});
    @(posedge clk_i);
    p_inv <= 1'b0;
    p_range <= 3'h0;
    $display("end of protection test");
    for (int j = 0; j < 3; j++) begin
      wren();
      cmd(ops[j], 24'h01A345, 0, 0, 0);
      outcome(1'b1, 1'b0);
      check(er_q.size(), 1);
      if (er_q.size() != 0) check(er_q.pop_front(), ers[j]);
    end
    $display("end of erase test");
    wren();
    cmd(8'h02, 24'h000000, 258, 0, 0);
    outcome(1'b1, 1'b0);
    expect_prog(24'h000000, 258);
    $display("end of overlong program test");
    report_and_stop();
  end
endmodule : fpes_sequencer_bench
